// ---- logic/motor_overload_current_limiter.sv ----
// motor overload limiter: load accumulation, peak/rated selection, object access
// assumes the measured current is a magnitude in mA, synchronous to ref_clk_i
`timescale 1ns/10ps
`default_nettype none

module motor_overload_current_limiter #(
  parameter int STEP_CYCLES = overload_pkg::STEP_CYCLES
) (
  // clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_n_i,
  // object access
  input  wire overload_pkg::od_req_type od_req_i,
  output var  overload_pkg::od_rsp_type od_rsp_o,
  // current path
  input  wire logic [31:0]             meas_current_i,
  output logic      [31:0]             current_limit_o,
  output logic                         limiter_active_o
);

  typedef struct packed {
    logic [31:0]                 submode;
    logic [31:0]                 peak;
    logic [31:0]                 rated;
    logic [31:0]                 duration;
    logic [31:0]                 threshold;
    logic [31:0]                 load;
    logic [31:0]                 limit;
    logic [31:0]                 step_cnt;
    overload_pkg::lim_state_type fsm;
    overload_pkg::od_rsp_type    rsp;
  } state_type;

  state_type state_r;
  state_type state_nxt;
  logic      rst_meta_r;
  logic      rst_sync_r;

  // release of the reset is synchronised, assertion stays asynchronous
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  function automatic logic [15:0] sat16(input logic [31:0] v);
    sat16 = (v[31:16] != 16'h0000) ? 16'hFFFF : v[15:0];
  endfunction

  function automatic logic is_obj(input overload_pkg::od_req_type r,
                                  input logic [15:0] idx, input logic [7:0] sub);
    is_obj = (r.index == idx) && (r.sub == sub);
  endfunction

  logic        closed_loop;
  logic        setup_ok;
  logic        step;
  logic [31:0] diff;
  logic [32:0] sum;

  always_comb begin
    state_nxt   = state_r;
    state_nxt.rsp.ack = 1'b0;
    state_nxt.rsp.err = 1'b0;
    // R1 closed loop select
    closed_loop = state_r.submode[overload_pkg::CLOSED_LOOP_BIT];
    // R10 setup check
    setup_ok    = (state_r.peak > state_r.rated) && (state_r.duration != 32'h0000_0000);
    // R11 limit from settings
    state_nxt.threshold = sat16(state_r.peak - state_r.rated) * sat16(state_r.duration);
    step = (state_r.step_cnt == 32'(STEP_CYCLES - 1));
    state_nxt.step_cnt = step ? 32'h0000_0000 : state_r.step_cnt + 32'h0000_0001;
    diff = 32'h0000_0000;
    sum  = 33'h0_0000_0000;

    if (!setup_ok) begin
      state_nxt.fsm  = overload_pkg::LIM_OFF;
      state_nxt.load = 32'h0000_0000;
    end else if (!closed_loop) begin
      // R2 open loop clamp
      state_nxt.fsm  = overload_pkg::LIM_OPEN;
      state_nxt.load = 32'h0000_0000;
    end else begin
      if (step) begin
        if (meas_current_i > state_r.rated) begin
          // R13 load carries over
          diff = meas_current_i - state_r.rated;
          sum  = {1'b0, state_r.load} + {1'b0, diff};
          state_nxt.load = sum[32] ? 32'hFFFF_FFFF : sum[31:0];
        end else begin
          // R14 load drains below rated
          diff = state_r.rated - meas_current_i;
          state_nxt.load = (state_r.load > diff) ? state_r.load - diff : 32'h0000_0000;
        end
      end
      // R12 switch to rated at the limit
      state_nxt.fsm = (state_nxt.load >= state_nxt.threshold) ? overload_pkg::LIM_RATED
                                                              : overload_pkg::LIM_PEAK;
    end

    unique case (state_nxt.fsm)
      // R3 peak as ceiling
      overload_pkg::LIM_OFF:   state_nxt.limit = state_r.peak;
      overload_pkg::LIM_PEAK:  state_nxt.limit = state_r.peak;
      // R4 rated as fallback
      overload_pkg::LIM_OPEN:  state_nxt.limit = state_r.rated;
      overload_pkg::LIM_RATED: state_nxt.limit = state_r.rated;
      default:                 state_nxt.limit = state_r.rated;
    endcase

    if (od_req_i.req) begin
      state_nxt.rsp.ack = 1'b1;
      state_nxt.rsp.rdata = 32'h0000_0000;
      if (od_req_i.we) begin
        // R5 duration setting, with peak and rated alongside
        if (is_obj(od_req_i, overload_pkg::IDX_PEAK_CURRENT, overload_pkg::SUB_MAIN)) begin
          state_nxt.peak = od_req_i.wdata;
        end else if (is_obj(od_req_i, overload_pkg::IDX_OVERLOAD, overload_pkg::SUB_RATED)) begin
          state_nxt.rated = od_req_i.wdata;
        end else if (is_obj(od_req_i, overload_pkg::IDX_OVERLOAD,
                            overload_pkg::SUB_DURATION)) begin
          state_nxt.duration = od_req_i.wdata;
        end else if (is_obj(od_req_i, overload_pkg::IDX_SUBMODE, overload_pkg::SUB_MAIN)) begin
          state_nxt.submode = od_req_i.wdata;
        end else begin
          // read-only or unknown objects refuse writes
          state_nxt.rsp.err = 1'b1;
        end
      end else begin
        if (is_obj(od_req_i, overload_pkg::IDX_PEAK_CURRENT, overload_pkg::SUB_MAIN)) begin
          state_nxt.rsp.rdata = state_r.peak;
        end else if (is_obj(od_req_i, overload_pkg::IDX_OVERLOAD, overload_pkg::SUB_RATED)) begin
          state_nxt.rsp.rdata = state_r.rated;
        end else if (is_obj(od_req_i, overload_pkg::IDX_OVERLOAD,
                            overload_pkg::SUB_DURATION)) begin
          state_nxt.rsp.rdata = state_r.duration;
        end else if (is_obj(od_req_i, overload_pkg::IDX_OVERLOAD,
                            overload_pkg::SUB_THRESHOLD)) begin
          // R6 threshold readback
          state_nxt.rsp.rdata = state_r.threshold;
        end else if (is_obj(od_req_i, overload_pkg::IDX_OVERLOAD, overload_pkg::SUB_LOAD)) begin
          // R7 load readback
          state_nxt.rsp.rdata = state_r.load;
        end else if (is_obj(od_req_i, overload_pkg::IDX_OVERLOAD, overload_pkg::SUB_LIMIT)) begin
          // R8 applied limit readback
          state_nxt.rsp.rdata = state_r.limit;
        end else if (is_obj(od_req_i, overload_pkg::IDX_OVERLOAD, overload_pkg::SUB_STATUS)) begin
          // R9 status value
          state_nxt.rsp.rdata = (state_r.fsm == overload_pkg::LIM_PEAK ||
                                 state_r.fsm == overload_pkg::LIM_RATED)
                                ? overload_pkg::STATUS_ON : overload_pkg::STATUS_OFF;
        end else if (is_obj(od_req_i, overload_pkg::IDX_SUBMODE, overload_pkg::SUB_MAIN)) begin
          state_nxt.rsp.rdata = state_r.submode;
        end else begin
          state_nxt.rsp.err = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r.submode   <= overload_pkg::RST_SUBMODE;
      state_r.peak      <= overload_pkg::RST_PEAK;
      state_r.rated     <= overload_pkg::RST_RATED;
      state_r.duration  <= overload_pkg::RST_DURATION;
      state_r.threshold <= 32'h0000_0000;
      state_r.load      <= 32'h0000_0000;
      state_r.limit     <= 32'h0000_0000;
      state_r.step_cnt  <= 32'h0000_0000;
      state_r.fsm       <= overload_pkg::LIM_OFF;
      state_r.rsp       <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign od_rsp_o         = state_r.rsp;
  assign current_limit_o  = state_r.limit;
  assign limiter_active_o = (state_r.fsm == overload_pkg::LIM_PEAK) ||
                            (state_r.fsm == overload_pkg::LIM_RATED);

endmodule // motor_overload_current_limiter

`default_nettype wire

// ---- pkg/overload_pkg.sv ----
// constants, types and object map of the motor overload limiter
// assumes one regulation clock and object-dictionary style index/subindex access
// Behaviour
// R1: Overload limiting runs only while bit 0 of the drive submode object selects closed loop.
// R2: With a valid setup in open loop the current is clamped to the rated current.
// R3: The peak current setting in mA is the highest current allowed before the limit is reached.
// R4: The rated current setting in mA is the fallback current once the limit is reached.
// R5: The peak duration setting in ms is how long peak current may flow.
// R6: A readable threshold decides whether peak or rated current is applied.
// R7: The accumulated load compared against the threshold is readable.
// R8: The current limit being applied is readable at all times.
// R9: The status object reads 0 while the limiter is inactive and 1 while active.
// R10: Peak above rated and a nonzero duration are needed, else the limiter stays off.
// R11: The limit value is derived from the rated current, peak current and peak duration.
// R12: Peak current is allowed until the load reaches the limit, then rated current at once.
// R13: Load left from earlier over-rated intervals carries over to later peak intervals.
// R14: Below rated current the load drains so peak current returns under the threshold.
package overload_pkg;

  // object dictionary map
  localparam logic [15:0] IDX_PEAK_CURRENT = 16'h2031;
  localparam logic [15:0] IDX_OVERLOAD     = 16'h203B;
  localparam logic [15:0] IDX_SUBMODE      = 16'h3202;
  localparam logic [7:0]  SUB_MAIN         = 8'h00;
  localparam logic [7:0]  SUB_RATED        = 8'h01;
  localparam logic [7:0]  SUB_DURATION     = 8'h02;
  localparam logic [7:0]  SUB_THRESHOLD    = 8'h03;
  localparam logic [7:0]  SUB_LOAD         = 8'h04;
  localparam logic [7:0]  SUB_LIMIT        = 8'h05;
  localparam logic [7:0]  SUB_STATUS       = 8'h06;
  localparam int          CLOSED_LOOP_BIT  = 0;

  // values after reset, and the status object values
  localparam logic [31:0] RST_PEAK     = 32'h0000_0000;
  localparam logic [31:0] RST_RATED    = 32'h0000_0000;
  localparam logic [31:0] RST_DURATION = 32'h0000_0000;
  localparam logic [31:0] RST_SUBMODE  = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFF   = 32'h0000_0000;
  localparam logic [31:0] STATUS_ON    = 32'h0000_0001;

  // accumulation step of one millisecond
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOAD_STEP_US  = 1000;
  localparam int STEP_CYCLES   = (LOAD_STEP_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    LIM_OFF   = 4'h1,
    LIM_OPEN  = 4'h2,
    LIM_PEAK  = 4'h4,
    LIM_RATED = 4'h8
  } lim_state_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } od_req_type;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } od_rsp_type;

endpackage

// ---- test/motor_overload_current_limiter_tb_top.sv ----
// testbench: object accesses and a motor stage driving the limiter through its phases
// assumes STEP_CYCLES of 4 so one load step is four clocks
`timescale 1ns/10ps
`default_nettype none
module motor_overload_current_limiter_tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  overload_pkg::od_req_type od_req = '0;
  overload_pkg::od_rsp_type od_rsp;
  logic [31:0] demand = 32'h0;
  logic [31:0] meas, limit;
  logic        active;
  int          bad_count = 0;
  int          comparisons = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  motor_overload_current_limiter #(.STEP_CYCLES(4)) DUT (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .od_req_i(od_req), .od_rsp_o(od_rsp), .meas_current_i(meas),
    .current_limit_o(limit), .limiter_active_o(active));
  motor_stage_model stage (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .demand_i(demand),
    .limit_i(limit), .current_o(meas));
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // one-cycle request pulse, answer awaited under a bound
  task automatic acc(input logic we, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, input logic [31:0] rd, input logic err);
    int n;
    @(negedge ref_clk_i);
    od_req = '{1'b1, we, idx, sub, wd};
    @(negedge ref_clk_i);
    od_req.req = 1'b0;
    for (n = 0; n < 4 && od_rsp.ack !== 1'b1; n++) @(negedge ref_clk_i);
    chk("ack", {31'h0, od_rsp.ack}, 32'h1);
    chk("err", {31'h0, od_rsp.err}, {31'h0, err});
    chk("rdata", od_rsp.rdata, rd);
    if (od_rsp.ack !== 1'b1) wrap_up();
  endtask
  task automatic wait_lim(input logic [31:0] v, input int bound);
    int n;
    for (n = 0; n < bound && limit !== v; n++) @(negedge ref_clk_i);
    chk("limit", limit, v);
    if (limit !== v) wrap_up();
  endtask
  initial begin
    repeat (8) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    acc(1'b0, 16'h2031, 8'h00, 32'h0, overload_pkg::RST_PEAK, 1'b0);
    acc(1'b0, 16'h1234, 8'h00, 32'h0, 32'h0, 1'b1);
    acc(1'b1, 16'h203B, 8'h03, 32'h1, 32'h0, 1'b1);
    // peak equal to rated: limiter must stay off
    acc(1'b1, 16'h2031, 8'h00, 32'h3E8, 32'h0, 1'b0);
    acc(1'b1, 16'h203B, 8'h01, 32'h3E8, 32'h0, 1'b0);
    acc(1'b1, 16'h203B, 8'h02, 32'h5, 32'h0, 1'b0);
    acc(1'b1, 16'h3202, 8'h00, 32'h1, 32'h0, 1'b0);
    acc(1'b0, 16'h203B, 8'h06, 32'h0, overload_pkg::STATUS_OFF, 1'b0);
    chk("off limit", limit, 32'h3E8);
    chk("off active", {31'h0, active}, 32'h0);
    acc(1'b1, 16'h2031, 8'h00, 32'hBB8, 32'h0, 1'b0);
    acc(1'b1, 16'h3202, 8'h00, 32'h0, 32'h0, 1'b0);
    wait_lim(32'h3E8, 8);
    acc(1'b0, 16'h203B, 8'h06, 32'h0, overload_pkg::STATUS_OFF, 1'b0);
    chk("open active", {31'h0, active}, 32'h0);
    demand = 32'hBB8;
    acc(1'b1, 16'h3202, 8'h00, 32'h1, 32'h0, 1'b0);
    acc(1'b0, 16'h203B, 8'h03, 32'h0, 32'h2710, 1'b0);
    acc(1'b0, 16'h203B, 8'h06, 32'h0, overload_pkg::STATUS_ON, 1'b0);
    chk("active", {31'h0, active}, 32'h1);
    wait_lim(32'hBB8, 8);
    wait_lim(32'h3E8, 60);
    acc(1'b0, 16'h203B, 8'h04, 32'h0, 32'h2710, 1'b0);
    acc(1'b0, 16'h203B, 8'h05, 32'h0, 32'h3E8, 1'b0);
    acc(1'b0, 16'h203B, 8'h02, 32'h0, 32'h5, 1'b0);
    demand = 32'h0;
    wait_lim(32'hBB8, 12);
    demand = 32'hBB8;
    wait_lim(32'h3E8, 14);
    wrap_up();
  end
endmodule // motor_overload_current_limiter_tb_top
`default_nettype wire

// ---- test/motor_stage_model.sv ----
// motor stage model: winding current follows demand, capped by the applied limit
// assumes the limit is a level in mA from the limiter
`timescale 1ns/10ps
`default_nettype none
module motor_stage_model (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // demand and limit in, winding current out
  input  wire logic [31:0] demand_i,
  input  wire logic [31:0] limit_i,
  output logic      [31:0] current_o
);
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) current_o <= 32'h0;
    else current_o <= (demand_i < limit_i) ? demand_i : limit_i;
  end
endmodule // motor_stage_model
`default_nettype wire

// ---- test/overload_checker_assertions.sv ----
// checker: object access handshake and peak/rated limit selection
// assumes settings change only through od_req_i
`timescale 1ns/10ps
`default_nettype none
module overload_checker #(parameter int STEP_CYCLES = 4) (
  input wire logic                     ref_clk_i,
  input wire logic                     rst_n_i,
  input wire overload_pkg::od_req_type od_req_i,
  input wire overload_pkg::od_rsp_type od_rsp_o,
  input wire logic [31:0]              meas_current_i,
  input wire logic [31:0]              current_limit_o,
  input wire logic                     limiter_active_o
);
  logic [31:0] pk_r, rt_r, du_r, sm_r;
  logic [2:0]  qc_r;
  wire logic wr = od_req_i.req && od_req_i.we;
  wire logic q  = qc_r == 3'h4;
  wire logic ok = pk_r > rt_r && du_r != 32'h0;
  // shadow settings; q marks a few quiet cycles after the last write
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {pk_r, rt_r, du_r, sm_r} <= '0;
      qc_r <= 3'h0;
    end else begin
      qc_r <= wr ? 3'h0 : (q ? qc_r : qc_r + 3'h1);
      if (wr && od_req_i.index == 16'h2031 && od_req_i.sub == 8'h00) pk_r <= od_req_i.wdata;
      if (wr && od_req_i.index == 16'h203B && od_req_i.sub == 8'h01) rt_r <= od_req_i.wdata;
      if (wr && od_req_i.index == 16'h203B && od_req_i.sub == 8'h02) du_r <= od_req_i.wdata;
      if (wr && od_req_i.index == 16'h3202 && od_req_i.sub == 8'h00) sm_r <= od_req_i.wdata;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ack_after_req: assert property (od_req_i.req |=> od_rsp_o.ack)
    else $error("no ack after request");
  a_ack_has_cause: assert property (od_rsp_o.ack |-> $past(od_req_i.req))
    else $error("ack without request");
  a_err_with_ack: assert property (od_rsp_o.err |-> od_rsp_o.ack)
    else $error("err without ack");
  a_ro_write_refused: assert property (wr && od_req_i.index == 16'h203B
    && od_req_i.sub >= 8'h03 && od_req_i.sub <= 8'h06 |=> od_rsp_o.err) else $error("ro write ok");
  a_active_needs_setup: assert property (limiter_active_o && q |-> sm_r[0] && ok)
    else $error("active without closed loop setup");
  a_open_loop_clamp: assert property (q && ok && !sm_r[0] |-> current_limit_o == rt_r)
    else $error("open loop not clamped to rated");
  a_invalid_stays_off: assert property (q && !ok |-> !limiter_active_o ##0 current_limit_o == pk_r)
    else $error("invalid setup not off");
  a_active_two_levels: assert property (limiter_active_o && q |->
    current_limit_o == pk_r || current_limit_o == rt_r) else $error("limit not peak or rated");
  c_active: cover property ($rose(limiter_active_o));
  c_rated: cover property (limiter_active_o && current_limit_o == rt_r);
  c_err: cover property (od_rsp_o.err);
endmodule // overload_checker
bind motor_overload_current_limiter overload_checker #(.STEP_CYCLES(STEP_CYCLES)) chk_i (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .od_req_i(od_req_i), .od_rsp_o(od_rsp_o),
  .meas_current_i(meas_current_i), .current_limit_o(current_limit_o),
  .limiter_active_o(limiter_active_o));
`default_nettype wire
